// ### include/pwei_defs.vh
// Purpose: Constants for the pin wake and external interrupt block
// Assumes: Plain register port with byte addresses as printed
// Notes:   Offsets are byte addresses on the system map
`ifndef PWEI_DEFS_VH
`define PWEI_DEFS_VH
`define PWEI_ADDR_W          32
`define PWEI_OFF_FLAGS       32'h4000A814
`define PWEI_OFF_CFG_A       32'h4000A860
`define PWEI_OFF_CFG_B       32'h4000A864
`define PWEI_OFF_CFG_C       32'h4000A868
`define PWEI_OFF_CFG_D       32'h4000A86C
`define PWEI_OFF_WAKE_A      32'h4000BC08
`define PWEI_OFF_WAKE_B      32'h4000BC0C
`define PWEI_OFF_WAKE_C      32'h4000BC10
`define PWEI_OFF_SEL_C       32'h4000BC14
`define PWEI_OFF_SEL_D       32'h4000BC18
`define PWEI_OFF_WFILT       32'h4000BC1C
`define PWEI_OFF_IMASK       32'h4000BC20
`define PWEI_OFF_WSTAT       32'h4000BC24
`define PWEI_SEL_C_RST       5'h0F
`define PWEI_SEL_D_RST       5'h10
`define PWEI_CFG_FILT_BIT    8
`define PWEI_CFG_MODE_HI     7
`define PWEI_CFG_MODE_LO     5
`define PWEI_MODE_OFF        3'h0
`define PWEI_MODE_RISE       3'h1
`define PWEI_MODE_FALL       3'h2
`define PWEI_MODE_BOTH       3'h3
`define PWEI_MODE_HIGH       3'h4
`define PWEI_MODE_LOW        3'h5
`define PWEI_WF_PINS_BIT     0
`define PWEI_WF_SERIAL_BIT   1
`define PWEI_WF_EXTD_BIT     3
`define PWEI_FLAG_A_BIT      0
`define PWEI_FLAG_C_BIT      2
`define PWEI_FLAG_D_BIT      3
`define PWEI_FLAG_MASK       4'hD
`define PWEI_SERIAL_RX_BIT   2
`define PWEI_FILT_CNT_W      3
`define PWEI_FILT_CNT_MAX    3'h7
`endif

// ### design/pwei_top.v
// Purpose: Wake monitoring and external interrupt detection for ports A, B and C
// Assumes: Pins asynchronous to i_core_clk; channel A and B inputs given as pins
// Notes:   Flag set wins over a clear written in the same cycle
// How it works
// - Each port has an eight-bit wake enable, one bit per pin, a one enabling monitoring.
// - Wake filter bit 0 filters all pin wake sources enabled by the port registers.
// - Wake filter bit 1 filters the serial receive wake source on port B bit 2.
// - Wake filter bit 3 filters the wake source of selectable interrupt D.
// - Two five-bit selects route a pin to interrupt C or D, codes above 0x17 reserved.
// - After reset the C select holds 0xF and the D select holds 0x10.
// - Channel config bit 8 enables digital filtering of that channel before detection.
// - Config bits 7 to 5 pick off, rising, falling, both, high level or low level.
// - Flags sit at bits 0, 2 and 3 for A, C and D, cleared by writing ones.
// - Config, wake filter, wake enable and flag registers all reset to zero.
`include "pwei_defs.vh"
module pwei_top (
   input  wire        i_core_clk,
   input  wire        i_rst,
   input  wire [7:0]  i_port_a_pin,
   input  wire [7:0]  i_port_b_pin,
   input  wire [7:0]  i_port_c_pin,
   input  wire        i_ext_int_a_pin,
   input  wire        i_ext_int_b_pin,
   input  wire [31:0] i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   output reg         o_irq,
   output reg         o_wake,
   output reg  [3:0]  o_ext_int_pulse
);
   // Pin vector: 0..7 port A, 8..15 B, 16..23 C, 24 chan A, 25 chan B
   wire [25:0] raw_pins = {i_ext_int_b_pin, i_ext_int_a_pin,
                           i_port_c_pin, i_port_b_pin, i_port_a_pin};
   reg  [25:0] sync_1;
   reg  [25:0] sync_2;
   reg  [25:0] filt_pin;
   wire [25:0] filt_next;

   reg  [7:0]  wake_en_a;
   reg  [7:0]  wake_en_b;
   reg  [7:0]  wake_en_c;
   reg  [3:0]  wake_filt;
   reg  [4:0]  sel_c;
   reg  [4:0]  sel_d;
   reg  [8:0]  cfg [0:3];
   reg  [3:0]  flags;
   reg  [3:0]  irq_mask;
   reg  [2:0]  wake_stat;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sync_1 <= 26'h0000000;
         sync_2 <= 26'h0000000;
      end else begin
         sync_1 <= raw_pins;
         sync_2 <= sync_1;
      end
   end

   // Glitch filter per pin; adds latency of the count, so short pulses vanish
   genvar g;
   generate
      for (g = 0; g < 26; g = g + 1) begin : g_filt
         reg [`PWEI_FILT_CNT_W-1:0] cnt;
         always @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
               cnt         <= {`PWEI_FILT_CNT_W{1'b0}};
               filt_pin[g] <= 1'b0;
            end else if (sync_2[g] == filt_pin[g]) begin
               cnt <= {`PWEI_FILT_CNT_W{1'b0}};
            end else if (cnt == `PWEI_FILT_CNT_MAX) begin
               cnt         <= {`PWEI_FILT_CNT_W{1'b0}};
               filt_pin[g] <= sync_2[g];
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate
   assign filt_next = filt_pin;

   // Pin select decode for C and D; reserved or unlisted codes give zero
   function pick;
      input [4:0]  code;
      input [25:0] pins;
      begin
         case (code)
            5'h04, 5'h05, 5'h07: pick = pins[code[2:0]];
            5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C: pick = pins[{2'b01, code[2:0]}];
            default: pick = (code[4:3] == 2'b10) ? pins[{2'b10, code[2:0]}] : 1'b0;
         endcase
      end
   endfunction

   wire [3:0] raw_src = {pick(sel_d, sync_2), pick(sel_c, sync_2),
                         sync_2[25], sync_2[24]};
   wire [3:0] flt_src = {pick(sel_d, filt_next), pick(sel_c, filt_next),
                         filt_next[25], filt_next[24]};

   reg  [3:0] chan_in;
   reg  [3:0] chan_prev;
   reg  [3:0] trig;
   integer k;
   always @* begin
      for (k = 0; k < 4; k = k + 1) begin
         chan_in[k] = cfg[k][`PWEI_CFG_FILT_BIT] ? flt_src[k] : raw_src[k];
         case (cfg[k][`PWEI_CFG_MODE_HI:`PWEI_CFG_MODE_LO])
            `PWEI_MODE_RISE: trig[k] = chan_in[k] & ~chan_prev[k];
            `PWEI_MODE_FALL: trig[k] = ~chan_in[k] & chan_prev[k];
            `PWEI_MODE_BOTH: trig[k] = chan_in[k] ^ chan_prev[k];
            `PWEI_MODE_HIGH: trig[k] = chan_in[k];
            `PWEI_MODE_LOW:  trig[k] = ~chan_in[k];
            default:         trig[k] = 1'b0;
         endcase
      end
   end

   // Wake sources: port pins, serial receive pin, interrupt D pin
   wire [23:0] wake_en = {wake_en_c, wake_en_b, wake_en_a};
   wire [23:0] pin_lvl = wake_filt[`PWEI_WF_PINS_BIT] ? filt_next[23:0]
                                                      : sync_2[23:0];
   reg  [23:0] pin_prev;
   wire        pin_wake = |(wake_en & (pin_lvl ^ pin_prev));
   wire        rx_lvl = wake_filt[`PWEI_WF_SERIAL_BIT] ?
                        filt_next[8 + `PWEI_SERIAL_RX_BIT] :
                        sync_2[8 + `PWEI_SERIAL_RX_BIT];
   reg         rx_prev;
   wire        rx_wake = rx_lvl ^ rx_prev;
   wire        d_lvl = wake_filt[`PWEI_WF_EXTD_BIT] ? flt_src[3]
                                                    : raw_src[3];
   reg         d_prev;
   wire        d_wake = d_lvl ^ d_prev;

   wire sel_hit_flags = i_addr == `PWEI_OFF_FLAGS;
   wire sel_hit_wstat = i_addr == `PWEI_OFF_WSTAT;

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wake_en_a <= 8'h00;
         wake_en_b <= 8'h00;
         wake_en_c <= 8'h00;
         wake_filt <= 4'h0;
         sel_c     <= `PWEI_SEL_C_RST;
         sel_d     <= `PWEI_SEL_D_RST;
         cfg[0]    <= 9'h000;
         cfg[1]    <= 9'h000;
         cfg[2]    <= 9'h000;
         cfg[3]    <= 9'h000;
         irq_mask  <= 4'h0;
      end else if (i_wr) begin
         case (i_addr)
            `PWEI_OFF_WAKE_A: wake_en_a <= i_wdata[7:0];
            `PWEI_OFF_WAKE_B: wake_en_b <= i_wdata[7:0];
            `PWEI_OFF_WAKE_C: wake_en_c <= i_wdata[7:0];
            `PWEI_OFF_WFILT:  wake_filt <= i_wdata[3:0] & 4'hB;
            `PWEI_OFF_SEL_C:  sel_c <= i_wdata[4:0];
            `PWEI_OFF_SEL_D:  sel_d <= i_wdata[4:0];
            `PWEI_OFF_CFG_A:  cfg[0] <= {i_wdata[8:5], 5'h00};
            `PWEI_OFF_CFG_B:  cfg[1] <= {i_wdata[8:5], 5'h00};
            `PWEI_OFF_CFG_C:  cfg[2] <= {i_wdata[8:5], 5'h00};
            `PWEI_OFF_CFG_D:  cfg[3] <= {i_wdata[8:5], 5'h00};
            `PWEI_OFF_IMASK:  irq_mask <= i_wdata[3:0] & `PWEI_FLAG_MASK;
            default: ;
         endcase
      end
   end

   // Set wins over a write-one clear in the same cycle
   wire [3:0] flag_clr = (i_wr && sel_hit_flags) ? i_wdata[3:0] : 4'h0;
   wire [2:0] wclr     = (i_wr && sel_hit_wstat) ? i_wdata[2:0] : 3'h0;
   wire [2:0] wset     = {d_wake, rx_wake, pin_wake};

   always @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         flags           <= 4'h0;
         wake_stat       <= 3'h0;
         chan_prev       <= 4'h0;
         pin_prev        <= 24'h000000;
         rx_prev         <= 1'b0;
         d_prev          <= 1'b0;
         o_rdata         <= 32'h00000000;
         o_irq           <= 1'b0;
         o_wake          <= 1'b0;
         o_ext_int_pulse <= 4'h0;
      end else begin
         chan_prev <= chan_in;
         pin_prev  <= pin_lvl;
         rx_prev   <= rx_lvl;
         d_prev    <= d_lvl;
         // Held level re-sets the flag in the same cycle as a clear, so it never reads clear
         flags <= ((flags & ~flag_clr) | trig) & `PWEI_FLAG_MASK;
         wake_stat <= (wake_stat & ~wclr) | wset;
         o_ext_int_pulse <= trig;
         o_irq  <= |(flags & irq_mask);
         o_wake <= |wake_stat;
         o_rdata <= 32'h00000000;
         if (i_rd) begin
            case (i_addr)
               `PWEI_OFF_FLAGS:  o_rdata <= {28'h0000000, flags};
               `PWEI_OFF_CFG_A:  o_rdata <= {23'h000000, cfg[0]};
               `PWEI_OFF_CFG_B:  o_rdata <= {23'h000000, cfg[1]};
               `PWEI_OFF_CFG_C:  o_rdata <= {23'h000000, cfg[2]};
               `PWEI_OFF_CFG_D:  o_rdata <= {23'h000000, cfg[3]};
               `PWEI_OFF_WAKE_A: o_rdata <= {24'h000000, wake_en_a};
               `PWEI_OFF_WAKE_B: o_rdata <= {24'h000000, wake_en_b};
               `PWEI_OFF_WAKE_C: o_rdata <= {24'h000000, wake_en_c};
               `PWEI_OFF_SEL_C:  o_rdata <= {27'h0000000, sel_c};
               `PWEI_OFF_SEL_D:  o_rdata <= {27'h0000000, sel_d};
               `PWEI_OFF_WFILT:  o_rdata <= {28'h0000000, wake_filt};
               `PWEI_OFF_IMASK:  o_rdata <= {28'h0000000, irq_mask};
               `PWEI_OFF_WSTAT:  o_rdata <= {29'h0000000, wake_stat};
               default:          o_rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// ### testbench/pwei_top_asserts.sv
// Purpose: Port assertions for pwei_top
// Assumes: Read data stands one cycle after the strobe
// Notes:   Pin timing is left to the bench
module pwei_chk (
   input wire        i_core_clk,
   input wire        i_rst,
   input wire [31:0] i_addr,
   input wire [31:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [31:0] o_rdata,
   input wire        o_irq,
   input wire        o_wake,
   input wire [3:0]  o_ext_int_pulse
);
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   property p_rd(logic [31:0] a, logic [31:0] z);
      i_rd && i_addr == a |=> (o_rdata & z) == 32'h0;
   endproperty
   chk_flag_zeros: assert property (p_rd(32'h4000A814, 32'hFFFFFFF2))
      else $error("flag spare bits set");
   chk_cfg_zeros: assert property (p_rd(32'h4000A860, 32'hFFFFFE1F))
      else $error("config spare bits set");
   chk_sel_c_width: assert property (p_rd(32'h4000BC14, 32'hFFFFFFE0))
      else $error("select c too wide");
   chk_sel_d_width: assert property (p_rd(32'h4000BC18, 32'hFFFFFFE0))
      else $error("select d too wide");
   chk_wake_width: assert property (p_rd(32'h4000BC10, 32'hFFFFFF00))
      else $error("wake enable too wide");
   chk_filt_zeros: assert property (p_rd(32'h4000BC1C, 32'hFFFFFFF4))
      else $error("wake filter spare bits set");
   chk_cfg_back: assert property (i_wr && i_addr == 32'h4000A86C ##1 !i_wr ##1 i_rd &&
      i_addr == 32'h4000A86C |=> o_rdata == ($past(i_wdata, 3) & 32'h1E0))
      else $error("config d readback");
   chk_rst_quiet: assert property ($fell(i_rst) |-> !o_irq && !o_wake && !o_ext_int_pulse)
      else $error("outputs busy after reset");
   cover property (o_irq);
   cover property (o_wake);
   cover property (o_ext_int_pulse[2]);
endmodule
bind pwei_top pwei_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_wake(o_wake), .o_ext_int_pulse(o_ext_int_pulse));

// ### testbench/pwei_pins.sv
// Purpose: Outside world driving the pins
// Assumes: Levels change after a clock edge
// Notes:   Skew keeps pin edges off the clock
module pwei_pins (
   input  wire  [25:0] i_lvl,
   output logic [25:0] o_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_pins = 26'h0;
   always @(i_lvl) o_pins <= #7 i_lvl;
endmodule

// ### testbench/pin_wake_and_ext_irq_test.sv
// Purpose: Self-checking bench for pwei_top
// Assumes: Register model in bench arrays
// Notes:   Glitches stay under the eight-edge filter
module pin_wake_and_ext_irq_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, wr = 0, rd = 0;
   logic [25:0] lvl = 0;
   logic [31:0] addr = 0, wdata = 0, mdl[12];
   wire  [25:0] pins;
   wire  [31:0] rdata;
   wire         irq, wake;
   wire  [3:0]  pls;
   logic [3:0]  pls_seen = 0;
   int          fail_count = 0, n_compared = 0, m, k, j;
   pwei_pins u_pins (.i_lvl(lvl), .o_pins(pins));
   pwei_top dut (.i_core_clk(clk), .i_rst(rst), .i_port_a_pin(pins[7:0]),
      .i_port_b_pin(pins[15:8]), .i_port_c_pin(pins[23:16]), .i_ext_int_a_pin(pins[24]),
      .i_ext_int_b_pin(pins[25]), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_irq(irq), .o_wake(wake), .o_ext_int_pulse(pls));
   always @(posedge clk) pls_seen <= pls_seen | pls;
   function automatic logic [31:0] adr(int i);
      return i < 4 ? 32'h4000A860 + 4 * i : i < 11 ? 32'h4000BBF8 + 4 * i : 32'h4000BC28;
   endfunction
   function automatic logic [31:0] msk(int i);
      return i < 4 ? 32'h1E0 : i < 7 ? 32'hFF : i < 9 ? 32'h1F : i < 10 ? 32'hB : i < 11 ? 32'hD : 0;
   endfunction
   task chk(input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr_reg(input logic [31:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd_chk(input logic [31:0] a, e);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata, e);
   endtask
   task wr_m(input int i, input logic [31:0] d);
      mdl[i] = d & msk(i);
      wr_reg(adr(i), d);
   endtask
   task pulse(input int b, n);
      @(posedge clk);
      lvl[b] <= 1;
      cyc(n);
      lvl[b] <= 0;
      cyc(24);
   endtask
   task give_verdict;
      $display("compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always #12.5 clk = ~clk;
   initial begin
      #(25 * 30000);
      fail_count++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h29C5));
      for (int i = 0; i < 12; i++)
         mdl[i] = i == 7 ? 32'hF : i == 8 ? 32'h10 : 32'h0;
      cyc(20);
      rst <= 0;
      rd_chk(32'h4000A814, 0);
      for (int i = 0; i < 12; i++) begin
         rd_chk(adr(i), mdl[i]);
         wr_m(i, $urandom);
         rd_chk(adr(i), mdl[i]);
      end
      for (int i = 0; i < 12; i++)
         wr_m(i, 0);
      wr_m(10, 1);
      // Level modes re-set at once, so wait before reading
      for (m = 0; m < 6; m++) begin
         wr_reg(32'h4000A860, m << 5);
         wr_reg(32'h4000A814, 32'hF);
         cyc(2);
         rd_chk(32'h4000A814, m == 5);
         lvl[24] <= 1;
         cyc(10);
         rd_chk(32'h4000A814, m == 1 || m > 2);
         wr_reg(32'h4000A814, 32'h1);
         cyc(2);
         rd_chk(32'h4000A814, m == 4);
         lvl[24] <= 0;
         cyc(10);
         rd_chk(32'h4000A814, m > 1);
         chk(irq, m > 1);
      end
      wr_m(10, 0);
      cyc(2);
      chk(irq, 0);
      wr_reg(32'h4000A860, 0);
      k = $urandom_range(7);
      for (j = 0; j < 2; j++) begin
         wr_reg(32'h4000BC14 + 4 * j, j ? 32'h8 + k % 5 : 32'h10 + k);
         wr_reg(32'h4000A868 + 4 * j, 32'h120);
         wr_reg(32'h4000A814, 32'hF);
         pulse(j ? 8 + k % 5 : 16 + k, 4);
         rd_chk(32'h4000A814, 0);
         pulse(j ? 8 + k % 5 : 16 + k, 12);
         rd_chk(32'h4000A814, 4 << j);
      end
      chk(pls_seen[3:2], 2'b11);
      wr_reg(32'h4000BC24, 32'h7);
      wr_reg(32'h4000BC08, 32'h1 << k);
      wr_reg(32'h4000BC1C, 32'h1);
      pulse(k, 4);
      chk(wake, 0);
      pulse(k, 12);
      chk(wake, 1);
      wr_reg(32'h4000BC24, 32'h7);
      pulse(10, 12);
      rd_chk(32'h4000BC24, (k % 5 == 2) ? 32'h6 : 32'h2);
      give_verdict();
   end
endmodule
